/* dpam_cfg.svh */
`ifndef DPAM_CFG_SVH
`define DPAM_CFG_SVH
// register byte offsets
`define DPAM_A_CTRL 8'h00
`define DPAM_A_SKEW 8'h04
`define DPAM_A_OFS 8'h08
`define DPAM_A_BW 8'h0c
`define DPAM_A_MODE 8'h10
`define DPAM_A_LIM 8'h14
`define DPAM_A_FRQ1 8'h18
`define DPAM_A_FRQ2 8'h1c
`define DPAM_A_FRQ3 8'h20
`define DPAM_A_PH1 8'h24
`define DPAM_A_PH2 8'h28
`define DPAM_A_STAT 8'h2c
// control field positions
`define DPAM_B_BUILDOUT_ENABLE 0
`define DPAM_B_CMP 1
`define DPAM_B_LSEL 2
`define DPAM_B_RECALIBRATE_REQUEST 3
`define DPAM_B_FRC_LO 4
`define DPAM_B_AUXBW 8
// reset values
`define DPAM_R_BUILDOUT_ENABLE 1'b0
`define DPAM_R_SKEW 8'h00
`define DPAM_R_OFS 17'h00000
`define DPAM_R_BW 5'h0a
`define DPAM_R_ILIM 8'hff
`define DPAM_R_SLIM 8'hff
// manual offset limit: 200 ns over 6 ps steps
`define DPAM_OFS_MAX 17'sh08235
`define DPAM_OFS_MIN (-17'sh08235)
// highest main bandwidth code, 21 settings
`define DPAM_BW_MAX 5'h14
// 100 Hz single pole at 40 MHz: 40e6/(2*pi*2^16)
`define DPAM_PH_SHIFT 16
`endif

/* dpam_pkg.sv */
`default_nettype none
package dpam_pkg;
  typedef enum logic [5:0] {
    DPAM_IDLE = 6'h01,
    DPAM_HOLD = 6'h02,
    DPAM_RAMP0 = 6'h04,
    DPAM_DIVRST = 6'h08,
    DPAM_RAMPUP = 6'h10,
    DPAM_EXIT = 6'h20
  } dpam_recalibrate_request_e;
  typedef enum logic [1:0] {
    DPAM_DIRECT = 2'h0,
    DPAM_LOCK_AT_8KHZ_MODE = 2'h1,
    DPAM_DIVN8K = 2'h2,
    DPAM_DIVNX = 2'h3
  } dpam_mode_e;
  typedef enum logic [1:0] {
    DPAM_FREERUN = 2'h0,
    DPAM_HOLDOVER = 2'h1,
    DPAM_LOCKING = 2'h2,
    DPAM_LOCKED = 2'h3
  } dpam_lstate_e;
endpackage : dpam_pkg
`default_nettype wire

/* dpam_top.sv */
// Notes on behaviour
// - add buildout skew at each buildout event while locking or locked, outside recalibration
// - buildout off: manual offset shifts locked phase
// - manual offset plus/minus 200 ns, 6 ps steps
// - offset applied in feedback clock path
// - offset frozen in free-run or holdover
// - recalibrate request starts one recalibration run
// - holdover, ramp zero, divider reset, ramp back
// - offset write during recalibrate_request retargets ramp
// - compare mode: aux free-runs, compares references
// - compare mode: software forces aux reference
// - main loop locking unaffected by compare
// - main copy divided when aux is DPAM_LOCK_AT_8KHZ_MODE or DPAM_DIVN8K and main is not DPAM_DIVNX
// - copy path chosen from main mode
// - frequency readback is integral value, three registers
// - loop select chooses readback source loop
// - phase readback averaged, 100 Hz corner
// - main phase is reference versus feedback
// - main bandwidth 21 codes, aux two
// - monitor frequency reported in 3.8 ppm units
// - input over frequency or slew limit invalid
// - buildout off: lock at manual offset phase
`timescale 1ns/1ps
`include "dpam_cfg.svh"
`default_nettype none
module dpam_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] main_state,
  input wire logic pbo_event,
  input wire logic [16:0] pbo_measured,
  input wire logic [23:0] main_integral,
  input wire logic [23:0] aux_integral,
  input wire logic [15:0] main_phase,
  input wire logic [15:0] aux_phase,
  input wire logic [2:0] aux_auto_sel,
  input wire logic mon_valid,
  input wire logic [2:0] mon_idx,
  input wire logic [15:0] mon_readback_a,
  output logic [16:0] fb_offset,
  output logic buildout_allowed,
  output logic mini_holdover,
  output logic div_reset,
  output logic aux_freerun,
  output logic aux_pd_compare,
  output logic [2:0] aux_ref_sel,
  output logic [1:0] copy_mode,
  output logic [1:0] main_lock_mode,
  output logic [1:0] aux_lock_mode,
  output logic [4:0] main_bw_sel,
  output logic aux_bw_70hz,
  output logic [7:0] input_invalid
);
  logic buildout_enable;
  logic aux_compare_main;
  logic readback_loop_select;
  logic recalibrate_request;
  logic [2:0] aux_force_select;
  logic [7:0] buildout_skew_reg;
  logic signed [16:0] manual_ofs;
  logic [4:0] bw_main;
  logic bw_aux;
  logic [1:0] mode_main;
  logic [1:0] mode_aux;
  logic [7:0] input_readback_a_limit;
  logic [7:0] slew_limit;
  logic [23:0] frq_snap;
  logic [15:0] ph_snap;
  logic dp_wr;
  logic [7:0] dp_addr;
  logic signed [31:0] ph_acc [2];
  logic signed [15:0] mon_prev [8];
  dpam_pkg::dpam_recalibrate_request_e recalibrate_request_st;
  dpam_pkg::dpam_recalibrate_request_e next_recalibrate_request_st;
  logic recalibrate_request_start;

  // ahb address phase
  wire logic addr_ok;
  wire logic [7:0] a8;
  wire logic wr_now;
  assign addr_ok = hsel && htrans[1] && hready;
  assign a8 = haddr[7:0];
  assign wr_now = dp_wr && hready;

  // averaged phase of both loops
  wire logic signed [15:0] ph_avg0;
  wire logic signed [15:0] ph_avg1;
  assign ph_avg0 = ph_acc[0][31:16];
  assign ph_avg1 = ph_acc[1][31:16];
  wire logic [23:0] frq_live;
  wire logic [15:0] ph_live;
  assign frq_live = readback_loop_select ? aux_integral : main_integral;
  assign ph_live = readback_loop_select ? ph_avg1 : ph_avg0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dp_wr <= addr_ok && hwrite;
      dp_addr <= addr_ok ? a8 : dp_addr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data and coherent snapshot
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h00000000;
      frq_snap <= 24'h000000;
      ph_snap <= 16'h0000;
    end else if (addr_ok && !hwrite) begin
      if (a8 == `DPAM_A_FRQ1) begin
        frq_snap <= frq_live;
        ph_snap <= ph_live;
      end
      case (a8)
        `DPAM_A_CTRL: hrdata <= {23'h000000, bw_aux, 1'b0, aux_force_select,
          recalibrate_request, readback_loop_select, aux_compare_main, buildout_enable};
        `DPAM_A_SKEW: hrdata <= {24'h000000, buildout_skew_reg};
        `DPAM_A_OFS: hrdata <= {15'h0000, manual_ofs};
        `DPAM_A_BW: hrdata <= {27'h0000000, bw_main};
        `DPAM_A_MODE: hrdata <= {28'h0000000, mode_aux, mode_main};
        `DPAM_A_LIM: hrdata <= {16'h0000, slew_limit, input_readback_a_limit};
        `DPAM_A_FRQ1: hrdata <= {24'h000000, frq_live[7:0]};
        `DPAM_A_FRQ2: hrdata <= {24'h000000, frq_snap[15:8]};
        `DPAM_A_FRQ3: hrdata <= {24'h000000, frq_snap[23:16]};
        `DPAM_A_PH1: hrdata <= {24'h000000, ph_snap[7:0]};
        `DPAM_A_PH2: hrdata <= {24'h000000, ph_snap[15:8]};
        `DPAM_A_STAT: hrdata <= {16'h0000, input_invalid, recalibrate_request_st != dpam_pkg::DPAM_IDLE,
          mini_holdover, 4'h0, main_state};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // software registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buildout_enable <= `DPAM_R_BUILDOUT_ENABLE;
      aux_compare_main <= 1'b0;
      readback_loop_select <= 1'b0;
      aux_force_select <= 3'h0;
      bw_aux <= 1'b0;
      buildout_skew_reg <= `DPAM_R_SKEW;
      manual_ofs <= `DPAM_R_OFS;
      bw_main <= `DPAM_R_BW;
      mode_main <= 2'h0;
      mode_aux <= 2'h0;
      input_readback_a_limit <= `DPAM_R_ILIM;
      slew_limit <= `DPAM_R_SLIM;
    end else if (wr_now) begin
      case (dp_addr)
        `DPAM_A_CTRL: begin
          buildout_enable <= hwdata[`DPAM_B_BUILDOUT_ENABLE];
          aux_compare_main <= hwdata[`DPAM_B_CMP];
          readback_loop_select <= hwdata[`DPAM_B_LSEL];
          aux_force_select <= hwdata[`DPAM_B_FRC_LO+:3];
          bw_aux <= hwdata[`DPAM_B_AUXBW];
        end
        `DPAM_A_SKEW: buildout_skew_reg <= hwdata[7:0];
        `DPAM_A_OFS: begin
          if ($signed(hwdata[16:0]) > `DPAM_OFS_MAX) begin
            manual_ofs <= `DPAM_OFS_MAX;
          end else if ($signed(hwdata[16:0]) < `DPAM_OFS_MIN) begin
            manual_ofs <= `DPAM_OFS_MIN;
          end else begin
            manual_ofs <= $signed(hwdata[16:0]);
          end
        end
        `DPAM_A_BW: bw_main <= (hwdata[4:0] > `DPAM_BW_MAX) ? `DPAM_BW_MAX : hwdata[4:0];
        `DPAM_A_MODE: begin
          mode_main <= hwdata[1:0];
          mode_aux <= hwdata[3:2];
        end
        `DPAM_A_LIM: begin
          input_readback_a_limit <= hwdata[7:0];
          slew_limit <= hwdata[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // recalibrate request, set by write, cleared on start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      recalibrate_request <= 1'b0;
    end else if (wr_now && dp_addr == `DPAM_A_CTRL && hwdata[`DPAM_B_RECALIBRATE_REQUEST]) begin
      recalibrate_request <= 1'b1;
    end else if (recalibrate_request_start) begin
      recalibrate_request <= 1'b0;
    end
  end
  assign recalibrate_request_start = recalibrate_request && recalibrate_request_st == dpam_pkg::DPAM_IDLE;

  // recalibration sequencer
  always_comb begin
    next_recalibrate_request_st = recalibrate_request_st;
    case (recalibrate_request_st)
      dpam_pkg::DPAM_IDLE: if (recalibrate_request_start) next_recalibrate_request_st = dpam_pkg::DPAM_HOLD;
      dpam_pkg::DPAM_HOLD: next_recalibrate_request_st = dpam_pkg::DPAM_RAMP0;
      dpam_pkg::DPAM_RAMP0: if (fb_offset == 17'h00000) next_recalibrate_request_st = dpam_pkg::DPAM_DIVRST;
      dpam_pkg::DPAM_DIVRST: next_recalibrate_request_st = dpam_pkg::DPAM_RAMPUP;
      dpam_pkg::DPAM_RAMPUP: if (fb_offset == manual_ofs) next_recalibrate_request_st = dpam_pkg::DPAM_EXIT;
      dpam_pkg::DPAM_EXIT: next_recalibrate_request_st = dpam_pkg::DPAM_IDLE;
      default: next_recalibrate_request_st = dpam_pkg::DPAM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      recalibrate_request_st <= dpam_pkg::DPAM_IDLE;
      mini_holdover <= 1'b0;
      div_reset <= 1'b0;
    end else begin
      recalibrate_request_st <= next_recalibrate_request_st;
      mini_holdover <= next_recalibrate_request_st != dpam_pkg::DPAM_IDLE &&
        next_recalibrate_request_st != dpam_pkg::DPAM_EXIT;
      div_reset <= next_recalibrate_request_st == dpam_pkg::DPAM_DIVRST;
    end
  end

  function automatic logic signed [16:0] dpam_step(input logic signed [16:0] cur,
    input logic signed [16:0] tgt);
    if (cur < tgt) begin
      return cur + 17'sh00001;
    end else if (cur > tgt) begin
      return cur - 17'sh00001;
    end
    return cur;
  endfunction : dpam_step

  // feedback path phase offset
  wire logic main_tracking;
  assign main_tracking = main_state[1]; // locking or locked
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fb_offset <= 17'h00000;
    end else if (recalibrate_request_st == dpam_pkg::DPAM_RAMP0) begin
      fb_offset <= dpam_step(fb_offset, 17'sh00000);
    end else if (recalibrate_request_st == dpam_pkg::DPAM_RAMPUP) begin
      fb_offset <= dpam_step(fb_offset, manual_ofs);
    end else if (recalibrate_request_st != dpam_pkg::DPAM_IDLE || !main_tracking) begin
      fb_offset <= fb_offset;
    end else if (buildout_enable) begin
      if (pbo_event) begin
        fb_offset <= fb_offset + pbo_measured + {{9{buildout_skew_reg[7]}}, buildout_skew_reg};
      end
    end else begin
      fb_offset <= dpam_step(fb_offset, manual_ofs);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buildout_allowed <= 1'b0;
    end else begin
      buildout_allowed <= buildout_enable;
    end
  end

  // auxiliary loop compare mode and copy path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aux_freerun <= 1'b0;
      aux_pd_compare <= 1'b0;
      aux_ref_sel <= 3'h0;
      copy_mode <= 2'h0;
      main_lock_mode <= 2'h0;
      aux_lock_mode <= 2'h0;
      main_bw_sel <= `DPAM_R_BW;
      aux_bw_70hz <= 1'b0;
    end else begin
      aux_freerun <= aux_compare_main;
      aux_pd_compare <= aux_compare_main;
      aux_ref_sel <= aux_compare_main ? aux_force_select : aux_auto_sel;
      main_lock_mode <= mode_main;
      aux_lock_mode <= mode_aux;
      main_bw_sel <= bw_main;
      aux_bw_70hz <= bw_aux;
      if (mode_aux == dpam_pkg::DPAM_LOCK_AT_8KHZ_MODE || mode_aux == dpam_pkg::DPAM_DIVN8K) begin
        case (mode_main)
          dpam_pkg::DPAM_DIRECT: copy_mode <= dpam_pkg::DPAM_LOCK_AT_8KHZ_MODE;
          dpam_pkg::DPAM_LOCK_AT_8KHZ_MODE: copy_mode <= dpam_pkg::DPAM_LOCK_AT_8KHZ_MODE;
          dpam_pkg::DPAM_DIVN8K: copy_mode <= dpam_pkg::DPAM_DIVN8K;
          default: copy_mode <= dpam_pkg::DPAM_DIRECT;
        endcase
      end else begin
        copy_mode <= dpam_pkg::DPAM_DIRECT;
      end
    end
  end

  // phase averaging, one pole per loop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_acc[0] <= 32'sh00000000;
      ph_acc[1] <= 32'sh00000000;
    end else begin
      ph_acc[0] <= ph_acc[0] + $signed({{16{main_phase[15]}}, main_phase}) -
        (ph_acc[0] >>> `DPAM_PH_SHIFT);
      ph_acc[1] <= ph_acc[1] + $signed({{16{aux_phase[15]}}, aux_phase}) -
        (ph_acc[1] >>> `DPAM_PH_SHIFT);
    end
  end

  // input validity from monitor readings
  wire logic signed [16:0] mon_f;
  wire logic signed [16:0] mon_d;
  wire logic [16:0] mon_fa;
  wire logic [16:0] mon_da;
  assign mon_f = {mon_readback_a[15], mon_readback_a};
  assign mon_d = mon_f - {mon_prev[mon_idx][15], mon_prev[mon_idx]};
  assign mon_fa = mon_f[16] ? 17'(-mon_f) : mon_f;
  assign mon_da = mon_d[16] ? 17'(-mon_d) : mon_d;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      input_invalid <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        mon_prev[i] <= 16'sh0000;
      end
    end else if (mon_valid) begin
      mon_prev[mon_idx] <= mon_readback_a;
      input_invalid[mon_idx] <= mon_fa > {9'h000, input_readback_a_limit} ||
        mon_da > {9'h000, slew_limit};
    end
  end

  sequence s_recalibrate_request_down;
    mini_holdover && fb_offset == 17'h00000 ##1 div_reset;
  endsequence
  sequence s_recalibrate_request_up;
    !div_reset && mini_holdover;
  endsequence

  a_recalibrate_request_enter: assert property (@(posedge clk) disable iff (!arst_n)
    recalibrate_request_start |=> recalibrate_request_st == dpam_pkg::DPAM_HOLD ##1 mini_holdover)
    else $error("recalibrate_request did not enter holdover");
  a_divrst_zero: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(div_reset) |-> $past(fb_offset) == 17'h00000 && mini_holdover)
    else $error("dividers reset with nonzero offset");
  a_recalibrate_request_order: assert property (@(posedge clk) disable iff (!arst_n)
    div_reset |=> s_recalibrate_request_up ##0 !div_reset)
    else $error("recalibrate_request order broken");
  a_recalibrate_request_exit: assert property (@(posedge clk) disable iff (!arst_n)
    recalibrate_request_st == dpam_pkg::DPAM_EXIT |-> $past(fb_offset) == $past(manual_ofs))
    else $error("recalibrate_request left before reaching offset");
  a_hold_freeze: assert property (@(posedge clk) disable iff (!arst_n)
    recalibrate_request_st == dpam_pkg::DPAM_IDLE && !main_tracking |=> $stable(fb_offset))
    else $error("offset moved in holdover");
  a_skew_add: assert property (@(posedge clk) disable iff (!arst_n)
    recalibrate_request_st == dpam_pkg::DPAM_IDLE && main_tracking && buildout_enable && pbo_event
    |=> fb_offset == 17'($past(fb_offset) + $past(pbo_measured) +
      {{9{$past(buildout_skew_reg[7])}}, $past(buildout_skew_reg)}))
    else $error("buildout skew not applied");
  a_manual_ramp: assert property (@(posedge clk) disable iff (!arst_n)
    recalibrate_request_st == dpam_pkg::DPAM_IDLE && main_tracking && !buildout_enable &&
    fb_offset != manual_ofs |=> fb_offset != $past(fb_offset))
    else $error("manual offset not tracked");
  a_ofs_range: assert property (@(posedge clk) disable iff (!arst_n)
    $signed(manual_ofs) <= `DPAM_OFS_MAX && $signed(manual_ofs) >= `DPAM_OFS_MIN)
    else $error("manual offset out of range");
  a_cmp_force: assert property (@(posedge clk) disable iff (!arst_n)
    aux_compare_main |=> aux_freerun && aux_ref_sel == $past(aux_force_select))
    else $error("compare mode wrong");
  a_copy_div: assert property (@(posedge clk) disable iff (!arst_n)
    mode_aux == dpam_pkg::DPAM_DIRECT |=> copy_mode == dpam_pkg::DPAM_DIRECT)
    else $error("copy divided with direct aux");
  a_bw_limit: assert property (@(posedge clk) disable iff (!arst_n)
    main_bw_sel <= `DPAM_BW_MAX)
    else $error("bandwidth code too high");
  a_snap_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !(addr_ok && !hwrite && a8 == `DPAM_A_FRQ1) |=> $stable(frq_snap) && $stable(ph_snap))
    else $error("snapshot changed without read");
  a_recalibrate_request_seq: assert property (@(posedge clk) disable iff (!arst_n)
    s_recalibrate_request_down |-> $past(mini_holdover) ##1 s_recalibrate_request_up)
    else $error("divider reset outside holdover");
endmodule : dpam_top
`default_nettype wire

/* dpam_loop_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpam_loop_model (
  input wire logic clk,
  output logic [1:0] main_state,
  output logic pbo_event,
  output logic [16:0] pbo_measured,
  output logic [23:0] main_integral,
  output logic [23:0] aux_integral,
  output logic [15:0] main_phase,
  output logic [15:0] aux_phase,
  output logic [2:0] aux_auto_sel,
  output logic mon_valid,
  output logic [2:0] mon_idx,
  output logic [15:0] mon_readback_a
);
  initial begin
    main_state = dpam_pkg::DPAM_LOCKED;
    pbo_event = 1'b0;
    pbo_measured = 17'h00000;
    main_integral = 24'h123456;
    aux_integral = 24'habcdef;
    main_phase = 16'h0000;
    aux_phase = 16'h0000;
    aux_auto_sel = 3'h2;
    mon_valid = 1'b0;
    mon_idx = 3'h0;
    mon_readback_a = 16'h0000;
  end
  // loop core state, detector and integral levels
  task drive(input logic [1:0] s, input logic [15:0] ph, input logic [23:0] mi);
    @(posedge clk);
    main_state <= s;
    main_phase <= ph;
    main_integral <= mi;
  endtask : drive
  // one buildout event, measured phase valid with the pulse only
  task phase_buildout(input logic [16:0] m);
    @(posedge clk);
    pbo_measured <= m;
    pbo_event <= 1'b1;
    @(posedge clk);
    pbo_event <= 1'b0;
    pbo_measured <= ~m;
  endtask : phase_buildout
  // one monitor sample in 3.8 ppm units
  task mon(input logic [2:0] idx, input logic [15:0] f);
    @(posedge clk);
    mon_idx <= idx;
    mon_readback_a <= f;
    mon_valid <= 1'b1;
    @(posedge clk);
    mon_valid <= 1'b0;
    mon_idx <= ~idx;
    mon_readback_a <= ~f;
  endtask : mon
endmodule : dpam_loop_model
`default_nettype wire

/* tb_dpll_phase_adjust_measure.sv */
`timescale 1ns/1ps
`include "dpam_cfg.svh"
`default_nettype none
module tb_dpll_phase_adjust_measure;
  logic clk, arst_n, hsel, hwrite, hreadyout, hresp, pbo_event, mon_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, main_state, copy_mode, main_lock_mode, aux_lock_mode;
  logic [2:0] hsize, aux_auto_sel, mon_idx, aux_ref_sel;
  logic [16:0] pbo_measured, fb_offset;
  logic [23:0] main_integral, aux_integral;
  logic [15:0] main_phase, aux_phase, mon_readback_a, ph;
  logic buildout_allowed, mini_holdover, div_reset, aux_freerun, aux_pd_compare, aux_bw_70hz;
  logic [4:0] main_bw_sel;
  logic [7:0] input_invalid;
  logic [15:0] mf [5] = '{16'h0005, 16'h000b, 16'hfff5, 16'h0008, 16'h0004};
  logic [7:0] me [5] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h04};
  int bad_count, n_tests, a, m, i;
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  dpam_top dpam_top_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .main_state(main_state),
    .pbo_event(pbo_event), .pbo_measured(pbo_measured), .main_integral(main_integral),
    .aux_integral(aux_integral), .main_phase(main_phase), .aux_phase(aux_phase),
    .aux_auto_sel(aux_auto_sel), .mon_valid(mon_valid), .mon_idx(mon_idx),
    .mon_readback_a(mon_readback_a), .fb_offset(fb_offset), .buildout_allowed(buildout_allowed),
    .mini_holdover(mini_holdover), .div_reset(div_reset), .aux_freerun(aux_freerun),
    .aux_pd_compare(aux_pd_compare), .aux_ref_sel(aux_ref_sel), .copy_mode(copy_mode),
    .main_lock_mode(main_lock_mode), .aux_lock_mode(aux_lock_mode),
    .main_bw_sel(main_bw_sel), .aux_bw_70hz(aux_bw_70hz), .input_invalid(input_invalid));
  dpam_loop_model dpam_loop_model_inst (.clk(clk), .main_state(main_state),
    .pbo_event(pbo_event), .pbo_measured(pbo_measured), .main_integral(main_integral),
    .aux_integral(aux_integral), .main_phase(main_phase), .aux_phase(aux_phase),
    .aux_auto_sel(aux_auto_sel), .mon_valid(mon_valid), .mon_idx(mon_idx),
    .mon_readback_a(mon_readback_a));
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task tmo(input logic ok);
    if (ok !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
  endtask : tmo
  task wait_rdy;
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    tmo(k < 20);
  endtask : wait_rdy
  task wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, ad};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : wr
  task rdr(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, ad};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    d = hrdata;
  endtask : rdr
  task settle;
    repeat (3) @(negedge clk);
  endtask : settle
  task wfb(input logic [16:0] t, input int n);
    int k;
    for (k = 0; k < n && fb_offset !== t; k++) @(negedge clk);
    tmo(fb_offset === t);
  endtask : wfb
  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    bad_count = 0;
    n_tests = 0;
    @(negedge clk);
    chk("rst fb", 32'(fb_offset), 32'h0);
    chk("rst bw", 32'(main_bw_sel), 32'h0a);
    chk("rst bus", 32'({hreadyout, hresp}), 32'h2);
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rdr(`DPAM_A_LIM, rd);
    chk("lim", rd, 32'hffff);
    rdr(8'h40, rd);
    chk("unmapped", rd, 32'h0);
    wr(`DPAM_A_BW, 32'h1f);
    rdr(`DPAM_A_BW, rd);
    chk("bw clamp", 32'(main_bw_sel), 32'h14);
    chk("bw rd", rd, 32'h14);
    wr(`DPAM_A_CTRL, 32'h100);
    settle();
    chk("aux bw", 32'(aux_bw_70hz), 32'h1);
    wr(`DPAM_A_OFS, 32'h0ffff);
    rdr(`DPAM_A_OFS, rd);
    chk("ofs max", rd, 32'h08235);
    wr(`DPAM_A_OFS, 32'h10000);
    rdr(`DPAM_A_OFS, rd);
    chk("ofs min", rd, 32'h17dcb);
    wr(`DPAM_A_OFS, 32'h5);
    wfb(17'h5, 300);
    chk("ofs track", 32'(fb_offset), 32'h5);
    dpam_loop_model_inst.drive(dpam_pkg::DPAM_HOLDOVER, 16'h0, 24'h123456);
    wr(`DPAM_A_OFS, 32'h14);
    repeat (30) @(negedge clk);
    chk("ofs frozen", 32'(fb_offset), 32'h5);
    dpam_loop_model_inst.drive(dpam_pkg::DPAM_LOCKING, 16'h0, 24'h123456);
    wfb(17'h14, 100);
    wr(`DPAM_A_CTRL, 32'h108);
    for (i = 0; i < 20 && mini_holdover !== 1'b1; i++) @(negedge clk);
    tmo(mini_holdover);
    wr(`DPAM_A_OFS, 32'h1e);
    for (i = 0; i < 100 && div_reset !== 1'b1; i++) @(negedge clk);
    tmo(div_reset);
    chk("recalibrate_request zero", 32'({mini_holdover, fb_offset}), 32'h20000);
    for (i = 0; i < 200 && mini_holdover !== 1'b0; i++) @(negedge clk);
    tmo(~mini_holdover);
    chk("recalibrate_request back", 32'(fb_offset), 32'h1e);
    wr(`DPAM_A_SKEW, 32'hfe);
    wr(`DPAM_A_CTRL, 32'h1);
    dpam_loop_model_inst.phase_buildout(17'h0000a);
    settle();
    chk("pbo one", 32'({buildout_allowed, fb_offset}), 32'h20026);
    dpam_loop_model_inst.phase_buildout(17'h1fffc);
    settle();
    chk("pbo two", 32'(fb_offset), 32'h20);
    wr(`DPAM_A_CTRL, 32'h52);
    rdr(`DPAM_A_CTRL, rd);
    chk("ctrl rd", rd, 32'h52);
    for (a = 0; a < 4; a++) begin
      for (m = 0; m < 4; m++) begin
        wr(`DPAM_A_MODE, 32'((a << 2) | m));
        settle();
        i = (a == 1 || a == 2) ? ((m == 3) ? 0 : ((m == 2) ? 2 : 1)) : 0;
        chk("copy", 32'(copy_mode), 32'(i));
        chk("modes", 32'({aux_lock_mode, main_lock_mode}), 32'((a << 2) | m));
      end
    end
    chk("compare", 32'({aux_freerun, aux_pd_compare, aux_ref_sel}), 32'h1d);
    wr(`DPAM_A_CTRL, 32'h0);
    settle();
    chk("no compare", 32'({aux_freerun, aux_pd_compare, aux_ref_sel}), 32'h02);
    dpam_loop_model_inst.drive(dpam_pkg::DPAM_LOCKED, 16'h7fff, 24'h123456);
    repeat (2000) @(posedge clk);
    rdr(`DPAM_A_FRQ1, rd);
    chk("frq1", rd, 32'h56);
    dpam_loop_model_inst.drive(dpam_pkg::DPAM_LOCKED, 16'h7fff, 24'h000000);
    rdr(`DPAM_A_FRQ2, rd);
    chk("frq2", rd, 32'h34);
    rdr(`DPAM_A_FRQ3, rd);
    chk("frq3", rd, 32'h12);
    rdr(`DPAM_A_PH1, rd);
    ph[7:0] = rd[7:0];
    rdr(`DPAM_A_PH2, rd);
    ph[15:8] = rd[7:0];
    chk("phase avg", 32'(ph >= 16'h0380 && ph <= 16'h0400), 32'h1);
    wr(`DPAM_A_CTRL, 32'h4);
    rdr(`DPAM_A_FRQ1, rd);
    chk("aux frq1", rd, 32'hef);
    rdr(`DPAM_A_FRQ3, rd);
    chk("aux frq3", rd, 32'hab);
    rdr(`DPAM_A_PH1, rd);
    chk("aux ph1", rd, 32'h0);
    wr(`DPAM_A_LIM, 32'hff0a);
    for (i = 0; i < 5; i++) begin
      if (i == 4) begin
        wr(`DPAM_A_LIM, 32'h030a);
      end
      dpam_loop_model_inst.mon(3'h2, mf[i]);
      settle();
      chk("invalid", 32'(input_invalid), 32'(me[i]));
    end
    rdr(`DPAM_A_STAT, rd);
    chk("stat invalid", 32'(rd[15:8]), 32'h04);
    chk("stat state", 32'(rd[7:0]), 32'h03);
    wrap_up();
  end
endmodule : tb_dpll_phase_adjust_measure
`default_nettype wire
